// [logic/sample_queue_pkg.sv]
// Purpose: Shared constants for the sample queue, delta and identity registers
// Assumes: Byte-wide register file reached by register address, one clock
// Notes:   Register offsets are the printed byte addresses
//
// Summary of operation
// - Temperature delta is signed Q8.4, low nibble zero
// - Delta equals newest minus previous temperature
// - Delta updates in every queue mode
// - Identifier register read-only, from factory value
// - Six-bit count gives samples held, zero empty
// - Overflow flag set while count is thirty-two
// - Level flag set at threshold, held above
// - Flags follow conditions; status read clears cause
// - Zero threshold never raises level flag
// - Passing threshold never blocks new samples
// - One sample pushed per acquisition tick
// - Mode: off, circular, stop, unused
// - Circular full: drop oldest, keep newest
// - Disable or standby-to-active flushes the store, not the input buffer
// - Each data read returns next byte; fifth byte pops
// - Enabled queue serves data at pressure-high address
// - Sample read as five bytes, 160 total
// - Sampling continues during host data reads
// - Overflow or threshold hit sets interrupt cause
// - Tick counter runs after overflow, clears empty
package sample_queue_pkg;
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] ADDR_PRESS_HIGH  = 8'h01; // Pressure high byte
   localparam logic [7:0] ADDR_PRESS_MID   = 8'h02; // Pressure middle byte
   localparam logic [7:0] ADDR_PRESS_LOW   = 8'h03; // Pressure low byte
   localparam logic [7:0] ADDR_TEMP_HIGH   = 8'h04; // Temperature high byte
   localparam logic [7:0] ADDR_TEMP_LOW    = 8'h05; // Temperature low byte
   localparam logic [7:0] ADDR_TDELTA_HIGH = 8'h0a; // temp_delta_high
   localparam logic [7:0] ADDR_TDELTA_LOW  = 8'h0b; // temp_delta_low
   localparam logic [7:0] ADDR_PART_ID     = 8'h0c; // part_identifier
   localparam logic [7:0] ADDR_QSTATE      = 8'h0d; // queue_state
   localparam logic [7:0] ADDR_QREAD       = 8'h0e; // queue_read_port
   localparam logic [7:0] ADDR_QCONFIG     = 8'h0f; // queue_config
   localparam logic [7:0] ADDR_TICK_CNT    = 8'h10; // overflow_tick_counter
   // ****************************************************************
   // Field layout and sizes
   // ****************************************************************
   localparam int          DEPTH        = 32;     // Samples held
   localparam int          BYTES_PER    = 5;      // Bytes per sample
   localparam logic [5:0]  COUNT_FULL   = 6'h20;  // Thirty-two samples
   localparam logic [5:0]  COUNT_ZERO   = 6'h00;  // Empty
   localparam logic [2:0]  BYTE_LAST    = 3'h4;   // Index of last byte
   localparam logic [3:0]  NIBBLE_ZERO  = 4'h0;   // Reserved low nibble
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;  // Zero byte
   localparam logic [7:0]  CONFIG_RESET = 8'h00;  // queue_config reset
   localparam logic [7:0]  TICK_MAX     = 8'hff;  // Tick counter saturates
   localparam logic [7:0]  PART_ID_DEF  = 8'h5a;  // Arbitrary identifier value
   // Overflow modes
   typedef enum logic [1:0] {
      MODE_OFF      = 2'b00,
      MODE_CIRCULAR = 2'b01,
      MODE_STOP     = 2'b10,
      MODE_UNUSED   = 2'b11
   } queue_mode_t;
endpackage : sample_queue_pkg

// [logic/sample_queue_regs.sv]
// Purpose: Sample queue with status/config, temperature delta and identifier
// Assumes: Register access by address with read and write strobes, one clock
// Notes:   Samples arrive through a two-entry buffer; reset and active mode pin pass two flops
`timescale 1ns/1ps
module sample_queue_regs #(
   parameter logic [7:0] PART_ID = sample_queue_pkg::PART_ID_DEF // Arbitrary value
) (
   input  wire logic        clk_sys,         // 20 MHz system clock
   input  wire logic        reset_n,         // Async reset, active low
   input  wire logic        sample_valid,    // New sample offered
   output logic             sample_ready,    // Buffer has room
   input  wire logic [19:0] sample_press,    // Pressure Q18.2
   input  wire logic [11:0] sample_temp,     // Temperature Q8.4
   input  wire logic        acq_tick,        // Acquisition tick pulse
   input  wire logic        active_mode,     // Level: system active
   input  wire logic [7:0]  reg_addr,        // Register address
   input  wire logic        reg_rd,          // Read strobe
   input  wire logic        reg_wr,          // Write strobe
   input  wire logic [7:0]  reg_wdata,       // Write data
   output logic [7:0]       reg_rdata,       // Read data, next cycle
   output logic             queue_interrupt_cause, // Cause bit
   output logic [7:0]       overflow_tick_counter  // Tick counter
);
   // ****************************************************************
   // Reset and pin synchronisers
   // ****************************************************************
   logic       rst_s1_r;               // Reset stage one
   logic       rst_n_r;                // Released reset
   logic [1:0] act_sync_r;             // Active mode sync

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // Active mode pin, two flops before use
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         act_sync_r <= 2'b00;
      end else begin
         act_sync_r <= {act_sync_r[0], active_mode};
      end
   end

   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0]  config_r, config_nxt;       // queue_config
   logic        act_prev_r;                 // Last active level
   logic [11:0] temp_prev_r, temp_prev_nxt; // Previous temperature
   logic [11:0] tdelta_r, tdelta_nxt;       // temp_difference_value
   logic [2:0]  byte_idx_r, byte_idx_nxt;   // Byte within head sample
   logic        ovf_seen_r, ovf_seen_nxt;   // Overflow/wrap seen
   logic        cause_r, cause_nxt;         // Interrupt cause
   logic [7:0]  tick_r, tick_nxt;           // Tick counter
   logic [7:0]  rdata_nxt;                  // Read data
   logic        lvl_prev_r;                 // Last level event
   logic        ovf_prev_r;                 // Last overflow level

   // Buffer and store wiring
   logic        buf_valid;                  // Buffered sample ready
   logic        buf_take;                   // Buffer drain
   logic [31:0] buf_data;                   // Buffered sample
   logic [31:0] head;                       // Oldest stored sample
   logic [5:0]  count;                      // queue_sample_count
   logic        store_wr;                   // Store write
   logic        store_pop;                  // Store pop
   logic        flush;                      // Flush request
   logic        full;                       // Thirty-two held
   logic        ovf_flag;                   // queue_overflow_flag
   logic        lvl_flag;                   // queue_level_flag
   logic        data_rd;                    // Data port read
   sample_queue_pkg::queue_mode_t mode;     // Decoded mode
   logic [5:0]  threshold;                  // queue_level_threshold

   // Byte select of a stored sample, high pressure first
   function automatic logic [7:0] sample_byte(input logic [31:0] s, input logic [2:0] i);
      case (i)
         3'h0:    sample_byte = s[31:24];
         3'h1:    sample_byte = s[23:16];
         3'h2:    sample_byte = s[15:8];
         3'h3:    sample_byte = s[7:0];
         default: sample_byte = s[7:0];
      endcase
   endfunction : sample_byte

   assign mode      = sample_queue_pkg::queue_mode_t'(config_r[7:6]);
   assign threshold = config_r[5:0];
   assign full      = (count == sample_queue_pkg::COUNT_FULL);
   assign ovf_flag  = full && (mode != sample_queue_pkg::MODE_OFF);
   // Level flag at or above threshold, never for zero
   assign lvl_flag  = (threshold != sample_queue_pkg::COUNT_ZERO) && (count >= threshold);
   assign flush     = (mode == sample_queue_pkg::MODE_OFF) || (act_sync_r[1] && !act_prev_r);
   // Data port read when enabled: at pressure high byte or at own address
   assign data_rd   = reg_rd && (mode != sample_queue_pkg::MODE_OFF) &&
                      ((reg_addr == sample_queue_pkg::ADDR_PRESS_HIGH) ||
                       (reg_addr == sample_queue_pkg::ADDR_QREAD));
   assign store_pop = data_rd && (count != sample_queue_pkg::COUNT_ZERO) &&
                      (byte_idx_r == sample_queue_pkg::BYTE_LAST);
   // Buffer drains on each acquisition tick; stop mode discards when full unless a pop frees a slot that cycle
   assign buf_take  = buf_valid && acq_tick;
   assign store_wr  = buf_take && (mode == sample_queue_pkg::MODE_CIRCULAR ||
                      (mode == sample_queue_pkg::MODE_STOP && !full) ||
                      (mode == sample_queue_pkg::MODE_STOP && store_pop)) && !flush;

   // ****************************************************************
   // Sample input buffer
   // ****************************************************************
   sample_skid_buffer #(.WIDTH(32)) u_buf (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n_r),
      .flush     (1'b0),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   ({sample_press, sample_temp}),
      .out_valid (buf_valid),
      .out_ready (acq_tick),
      .out_data  (buf_data)
   );

   // ****************************************************************
   // Sample store; circular full drops oldest as it writes
   // ****************************************************************
   sample_ring_store #(.WIDTH(32), .DEPTH(sample_queue_pkg::DEPTH)) u_store (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n_r),
      .flush     (flush),
      .wr_en     (store_wr),
      .wr_data   (buf_data),
      .pop       (store_pop || (store_wr && full && !store_pop)),
      .head_data (head),
      .count     (count)
   );

   // ****************************************************************
   // Next values
   // ****************************************************************
   always_comb begin
      config_nxt    = config_r;
      temp_prev_nxt = temp_prev_r;
      tdelta_nxt    = tdelta_r;
      byte_idx_nxt  = byte_idx_r;
      ovf_seen_nxt  = ovf_seen_r;
      cause_nxt     = cause_r;
      tick_nxt      = tick_r;
      rdata_nxt     = sample_queue_pkg::BYTE_ZERO;
      // Configuration write
      if (reg_wr && reg_addr == sample_queue_pkg::ADDR_QCONFIG) begin
         config_nxt = reg_wdata;
      end
      // Delta from every accepted sample, in any mode
      if (buf_take) begin
         temp_prev_nxt = buf_data[11:0];
         tdelta_nxt    = buf_data[11:0] - temp_prev_r;
      end
      // Byte walk through head sample
      if (flush) begin
         byte_idx_nxt = '0;
      end else if (data_rd && count != sample_queue_pkg::COUNT_ZERO) begin
         byte_idx_nxt = (byte_idx_r == sample_queue_pkg::BYTE_LAST) ? 3'h0 : byte_idx_r + 3'h1;
      end
      // Tick counter after overflow or wrap, clears when drained
      if (flush || (store_pop && count == 6'h01 && !store_wr)) begin
         ovf_seen_nxt = 1'b0;
         tick_nxt     = '0;
      end else begin
         if (ovf_flag) begin
            ovf_seen_nxt = 1'b1;
         end
         if (ovf_seen_r && acq_tick && tick_r != sample_queue_pkg::TICK_MAX) begin
            tick_nxt = tick_r + 8'h01;
         end
      end
      // Read mux
      if (reg_rd) begin
         unique case (reg_addr)
            sample_queue_pkg::ADDR_PRESS_HIGH,
            sample_queue_pkg::ADDR_QREAD: begin
               if (data_rd && count != sample_queue_pkg::COUNT_ZERO) begin
                  rdata_nxt = sample_byte({head[31:12], 12'h000} | {20'h0, head[11:0]}, byte_idx_r);
                  if (byte_idx_r == 3'h2) begin
                     rdata_nxt = {head[15:12], sample_queue_pkg::NIBBLE_ZERO};
                  end else if (byte_idx_r == 3'h3) begin
                     rdata_nxt = head[11:4];
                  end else if (byte_idx_r == sample_queue_pkg::BYTE_LAST) begin
                     rdata_nxt = {head[3:0], sample_queue_pkg::NIBBLE_ZERO};
                  end
               end
            end
            sample_queue_pkg::ADDR_TDELTA_HIGH: rdata_nxt = tdelta_r[11:4];
            sample_queue_pkg::ADDR_TDELTA_LOW:  rdata_nxt = {tdelta_r[3:0], sample_queue_pkg::NIBBLE_ZERO};
            sample_queue_pkg::ADDR_PART_ID:     rdata_nxt = PART_ID;
            sample_queue_pkg::ADDR_QSTATE:      rdata_nxt = {ovf_flag, lvl_flag, count};
            sample_queue_pkg::ADDR_QCONFIG:     rdata_nxt = config_r;
            sample_queue_pkg::ADDR_TICK_CNT:    rdata_nxt = tick_r;
            default:                            rdata_nxt = sample_queue_pkg::BYTE_ZERO;
         endcase
      end
      // Cause: rising edge of either event sets, status read clears; set wins
      if (reg_rd && reg_addr == sample_queue_pkg::ADDR_QSTATE) begin
         cause_nxt = 1'b0;
      end
      if ((ovf_flag && !ovf_prev_r) || (lvl_flag && !lvl_prev_r)) begin
         cause_nxt = 1'b1;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         config_r              <= sample_queue_pkg::CONFIG_RESET;
         act_prev_r            <= 1'b0;
         temp_prev_r           <= '0;
         tdelta_r              <= '0;
         byte_idx_r            <= '0;
         ovf_seen_r            <= 1'b0;
         cause_r               <= 1'b0;
         tick_r                <= '0;
         reg_rdata             <= sample_queue_pkg::BYTE_ZERO;
         lvl_prev_r            <= 1'b0;
         ovf_prev_r            <= 1'b0;
      end else begin
         config_r              <= config_nxt;
         act_prev_r            <= act_sync_r[1];
         temp_prev_r           <= temp_prev_nxt;
         tdelta_r              <= tdelta_nxt;
         byte_idx_r            <= byte_idx_nxt;
         ovf_seen_r            <= ovf_seen_nxt;
         cause_r               <= cause_nxt;
         tick_r                <= tick_nxt;
         reg_rdata             <= rdata_nxt;
         lvl_prev_r            <= lvl_flag;
         ovf_prev_r            <= ovf_flag;
      end
   end

   assign queue_interrupt_cause = cause_r;
   assign overflow_tick_counter = tick_r;
endmodule : sample_queue_regs

// [logic/sample_ring_store.sv]
// Purpose: Thirty-two entry sample memory with head/tail pointers
// Assumes: Caller decides when to write, drop oldest or pop
// Notes:   Write and pop in one cycle are both honoured
`timescale 1ns/1ps
module sample_ring_store #(
   parameter int WIDTH = 32,           // Sample width
   parameter int DEPTH = 32            // Samples held
) (
   input  wire logic             clk_sys,     // System clock
   input  wire logic             rst_n,       // Synchronised reset
   input  wire logic             flush,       // Empty the store
   input  wire logic             wr_en,       // Store a sample
   input  wire logic [WIDTH-1:0] wr_data,     // Sample in
   input  wire logic             pop,         // Remove oldest
   output logic [WIDTH-1:0]      head_data,   // Oldest sample
   output logic [$clog2(DEPTH):0] count      // Samples held
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];   // Sample array
   logic [AW-1:0]    wptr_r;          // Write pointer
   logic [AW-1:0]    wptr_nxt;        // Next write pointer
   logic [AW-1:0]    rptr_r;          // Read pointer
   logic [AW-1:0]    rptr_nxt;        // Next read pointer
   logic [AW:0]      cnt_r;           // Count
   logic [AW:0]      cnt_nxt;         // Next count

   assign head_data = mem_r[rptr_r];
   assign count     = cnt_r;

   // ****************************************************************
   // Pointer arithmetic
   // ****************************************************************
   always_comb begin
      wptr_nxt = wptr_r;
      rptr_nxt = rptr_r;
      cnt_nxt  = cnt_r;
      if (flush) begin
         wptr_nxt = '0;
         rptr_nxt = '0;
         cnt_nxt  = '0;
      end else begin
         if (wr_en) begin
            wptr_nxt = wptr_r + 1'b1;
         end
         if (pop) begin
            rptr_nxt = rptr_r + 1'b1;
         end
         cnt_nxt = cnt_r + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, pop};
      end
   end

   // Pointer registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r  <= '0;
      end else begin
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
         cnt_r  <= cnt_nxt;
      end
   end

   // Memory write, no reset needed
   always_ff @(posedge clk_sys) begin
      if (wr_en && !flush) begin
         mem_r[wptr_r] <= wr_data;
      end
   end
endmodule : sample_ring_store

// [logic/sample_skid_buffer.sv]
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Single clock, synchronous clear from flush
// Notes:   Full and empty are exact; ready drops when both entries hold
`timescale 1ns/1ps
module sample_skid_buffer #(
   parameter int WIDTH = 32            // Word width
) (
   input  wire logic             clk_sys,     // System clock
   input  wire logic             rst_n,       // Synchronised reset
   input  wire logic             flush,       // Drop contents
   input  wire logic             in_valid,    // Word offered
   output logic                  in_ready,    // Room for a word
   input  wire logic [WIDTH-1:0] in_data,     // Word in
   output logic                  out_valid,   // Word available
   input  wire logic             out_ready,   // Drain accepts
   output logic [WIDTH-1:0]      out_data     // Word out
);
   logic [WIDTH-1:0] slot_r [2];      // Storage
   logic [WIDTH-1:0] slot_nxt [2];    // Next storage
   logic [1:0]       fill_r;          // Entries held
   logic [1:0]       fill_nxt;        // Next entries held
   logic             push;            // Accepted write
   logic             pop;             // Accepted read
   logic             ready_r;         // Registered room flag

   // Room flag comes from a flop so the top-level output is registered
   assign in_ready  = ready_r;
   assign out_valid = (fill_r != 2'h0);
   assign out_data  = slot_r[0];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      slot_nxt = slot_r;
      fill_nxt = fill_r;
      if (flush) begin
         fill_nxt = 2'h0;
      end else begin
         // Shift on pop, then place the new word behind what stays
         if (pop) begin
            slot_nxt[0] = slot_r[1];
         end
         if (push) begin
            slot_nxt[(pop ? fill_r - 2'h1 : fill_r) == 2'h0 ? 0 : 1] = in_data;
         end
         fill_nxt = fill_r + {1'b0, push} - {1'b0, pop};
      end
   end

   // Register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fill_r <= 2'h0;
         ready_r <= 1'b1;
         slot_r <= '{default: '0};
      end else begin
         fill_r <= fill_nxt;
         ready_r <= (fill_nxt != 2'h2);
         slot_r <= slot_nxt;
      end
   end
endmodule : sample_skid_buffer

// [sim/host_model.sv]
// Purpose: Host side register access model
// Assumes: Strobes change at the falling edge
// Notes:   Read data taken one cycle after the strobe
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk_sys,   // Clock
   output logic [7:0]      reg_addr,  // Address
   output logic            reg_rd,    // Read strobe
   output logic            reg_wr,    // Write strobe
   output logic [7:0]      reg_wdata, // Write data
   input  wire logic [7:0] reg_rdata  // Read data
);
   initial begin
      reg_addr = 8'h00;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask : wr
   // One-cycle read strobe, data one cycle on
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask : rd
endmodule : host_model

// [sim/sample_queue_properties.sv]
// Purpose: Port checks for sample_queue_regs
// Assumes: One clock, reset_n active low
// Notes:   Bound to the design below the module
`timescale 1ns/1ps
module sample_queue_properties #(
   parameter logic [7:0] PART_ID = sample_queue_pkg::PART_ID_DEF // Identifier
) (
   input wire logic       clk_sys,               // Clock
   input wire logic       reset_n,               // Reset
   input wire logic       sample_valid,          // Word offered
   input wire logic       sample_ready,          // Buffer room
   input wire logic       acq_tick,              // Tick pulse
   input wire logic [7:0] reg_addr,              // Address
   input wire logic       reg_rd,                // Read strobe
   input wire logic [7:0] reg_rdata,             // Read data
   input wire logic       queue_interrupt_cause, // Cause bit
   input wire logic [7:0] overflow_tick_counter  // Tick counter
);
   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   logic st_rd; // Status register read
   assign st_rd = reg_rd && reg_addr == sample_queue_pkg::ADDR_QSTATE;
   AST_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("data without read");
   AST_ID: assert property (reg_rd && reg_addr == 8'h0c |=> reg_rdata == PART_ID) else $error("bad id");
   AST_NIB: assert property (reg_rd && reg_addr == 8'h0b |=> reg_rdata[3:0] == 4'h0) else $error("nibble");
   AST_CNT: assert property (st_rd |=> reg_rdata[5:0] <= 6'h20) else $error("count range");
   AST_OVF: assert property (st_rd |=> reg_rdata[7] == (reg_rdata[5:0] == 6'h20)) else $error("ovf");
   AST_CLR: assert property ($fell(queue_interrupt_cause) |-> $past(st_rd)) else $error("cause lost");
   AST_TSTEP: assert property (overflow_tick_counter != $past(overflow_tick_counter) |->
      overflow_tick_counter == $past(overflow_tick_counter) + 8'h01 || overflow_tick_counter == 8'h00)
      else $error("tick step");
   AST_TSRC: assert property (overflow_tick_counter == $past(overflow_tick_counter) + 8'h01 |->
      $past(acq_tick)) else $error("tick source");
   AST_RDY: assert property ($fell(sample_ready) |-> $past(sample_valid)) else $error("ready fell");
   CVR_CAUSE: cover property ($rose(queue_interrupt_cause));
   CVR_FULL: cover property (st_rd ##1 reg_rdata[7]);
   CVR_TICK: cover property (overflow_tick_counter != 8'h00);
endmodule : sample_queue_properties
bind sample_queue_regs sample_queue_properties #(.PART_ID(PART_ID)) sample_queue_properties_inst (
   .clk_sys(clk_sys), .reset_n(reset_n), .sample_valid(sample_valid), .sample_ready(sample_ready),
   .acq_tick(acq_tick), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .queue_interrupt_cause(queue_interrupt_cause), .overflow_tick_counter(overflow_tick_counter));

// [sim/tb_top.sv]
// Purpose: Self-checking bench for sample_queue_regs
// Assumes: Inputs change at the falling edge
// Notes:   Samples carry their index in the low byte
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0, reset_n = 1'b0, sample_valid = 1'b0, acq_tick = 1'b0, active_mode = 1'b1;
   logic [19:0] sample_press = 20'h0;
   logic [11:0] sample_temp = 12'h0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, tick_cnt, d;
   logic sample_ready, reg_rd, reg_wr, cause;
   int failures = 0, checks_done = 0, cycles = 0;
   always #25 clk_sys = ~clk_sys;
   sample_queue_regs sample_queue_regs_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_press(sample_press),
      .sample_temp(sample_temp), .acq_tick(acq_tick), .active_mode(active_mode), .reg_addr(reg_addr),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .queue_interrupt_cause(cause), .overflow_tick_counter(tick_cnt));
   host_model host_model_inst (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      host_model_inst.rd(a, d);
      chk(d, exp);
   endtask : rchk
   // Offer one sample, optionally move it to the store
   task automatic push(input int i, input logic tick);
      int n;
      n = 0;
      @(negedge clk_sys);
      sample_valid = 1'b1;
      sample_press = {12'ha5c, i[7:0]};
      sample_temp = {4'h9, i[7:0]};
      while (sample_ready !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      chk({7'h0, sample_ready}, 8'h01);
      @(negedge clk_sys);
      sample_valid = 1'b0;
      acq_tick = tick;
      @(negedge clk_sys);
      acq_tick = 1'b0;
   endtask : push
   // Five bytes of sample i from the shared address
   task automatic rs(input int i);
      rchk(8'h01, 8'ha5);
      rchk(8'h01, {4'hc, i[7:4]});
      rchk(8'h01, {i[3:0], 4'h0});
      rchk(8'h01, {4'h9, i[7:4]});
      rchk(8'h01, {i[3:0], 4'h0});
   endtask : rs
   task automatic t_regs;
      for (int a = 8'h0a; a <= 8'h0f; a++) rchk(a[7:0], a == 8'h0c ? sample_queue_pkg::PART_ID_DEF : 8'h00);
      host_model_inst.wr(8'h0c, 8'hff);
      rchk(8'h0c, sample_queue_pkg::PART_ID_DEF);
      $display("test regs done");
   endtask : t_regs
   task automatic t_circ;
      host_model_inst.wr(8'h0f, 8'h42);
      for (int i = 0; i <= 32; i++) push(i, 1'b1);
      chk({7'h0, cause}, 8'h01);
      chk(tick_cnt, 8'h01);
      rchk(8'h0d, 8'he0);
      chk({7'h0, cause}, 8'h00);
      rs(1);
      rchk(8'h02, 8'h00);
      rchk(8'h0d, 8'h5f);
      $display("test circular done");
   endtask : t_circ
   task automatic t_stop;
      host_model_inst.wr(8'h0f, 8'h00);
      rchk(8'h0d, 8'h00);
      host_model_inst.wr(8'h0f, 8'h80);
      for (int i = 0; i <= 32; i++) push(i, 1'b1);
      rchk(8'h0d, 8'ha0);
      rchk(8'h0a, 8'h00);
      rchk(8'h0b, 8'h10);
      chk(tick_cnt, 8'h01);
      for (int i = 0; i < 32; i++) rs(i);
      rchk(8'h01, 8'h00);
      rchk(8'h0d, 8'h00);
      chk(tick_cnt, 8'h00);
      $display("test stop done");
   endtask : t_stop
   task automatic t_flush;
      host_model_inst.wr(8'h0f, 8'h00);
      rchk(8'h0e, 8'h00);
      host_model_inst.wr(8'h0f, 8'h41);
      push(0, 1'b0);
      push(1, 1'b0);
      chk({7'h0, sample_ready}, 8'h00);
      @(negedge clk_sys);
      acq_tick = 1'b1;
      @(negedge clk_sys);
      acq_tick = 1'b0;
      repeat (2) push(2, 1'b1);
      rchk(8'h0d, 8'h43);
      active_mode = 1'b0;
      repeat (4) @(negedge clk_sys);
      active_mode = 1'b1;
      repeat (4) @(negedge clk_sys);
      rchk(8'h0d, 8'h00);
      $display("test flush done");
   endtask : t_flush
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      repeat (4) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      t_regs();
      t_circ();
      t_stop();
      t_flush();
      final_report();
   end
endmodule : tb_top
